// >>> logic/eal_eeprom_slave.sv
/*
  Two-wire serial eeprom slave: 512 bytes, 16-byte pages, one lock bit
  per page, self-timed programming with acknowledge polling.
  Assumes scl comes from the bus master and clocks the bit sampler;
  sda is open drain, resolved outside from sda_oe.
*/
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RQ1: address counter steps after each written data byte is acked; code steps it only when a further data byte starts
// RQ2: address counter steps for each byte read out
// RQ3: write command acked, then address byte loaded and acked
// RQ4: stop after data starts programming at address plus A8
// RQ5: programming erases selected bytes to ones, then writes buffer
// RQ6: data programming finishes within 8 ms of the stop
// RQ7: one to sixteen data bytes captured into page buffer
// RQ8: only low four address bits step during data entry
// RQ9: page bytes not entered stay unchanged
// RQ10: command bytes not acked while programming runs
// RQ11: after programming the counter keeps the last entered address
// RQ12: repeated start aborts a write without programming
// RQ13: after read command ack, a byte goes out msb first, counter steps
// RQ14: read without address setting uses the current counter
// RQ15: reading continues while master acks; nack then stop ends it
// RQ16: counter wraps from top location to zero
// RQ17: one lock bit per page; one allows changes, zero protects
// RQ18: write to a locked page suppresses programming
// RQ19: lock bit addressed by page bits, low four bits zero
// RQ20: lock ops: write command, address, start, same command, control
// RQ21: control byte low two bits: 00 read, 01 write, 11 erase
// RQ22: lock write or erase needs all sixteen bytes to match the page
// RQ23: command bit 0 selects read, bit 1 carries A8 on writes
// RQ24: lock programming only if all bytes verified, done within 4 ms
// RQ25: lock read returns page bit as msb, steps page, wraps
module eal_eeprom_slave #(
  parameter int PROG_CYC = eal_pkg::PROG_CYC_DEF,
  parameter int LOCK_CYC = eal_pkg::LOCK_CYC_DEF
) (
  // system
  input  wire logic clk,
  input  wire logic nrst,
  // serial link
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // status
  output logic      busy
);
  import eal_pkg::*;

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  logic             rx_bit_reg;
  logic             rx_tog_reg;
  logic [1:0]       tog_sync_reg;
  logic [1:0]       scl_sync_reg;
  logic [1:0]       sda_sync_reg;
  logic             tog_last_reg;
  logic             scl_last_reg;
  logic             sda_last_reg;
  eal_state_t       state_reg;
  logic [3:0]       bitcnt_reg;
  logic [7:0]       shift_reg;
  logic             ack_reg;
  logic [8:0]       addr_reg;
  logic [4:0]       page_reg;
  logic [7:0]       cmd_reg;
  logic [7:0]       wcmd_reg;
  logic             repeat_ok_reg;
  logic [15:0]      mask_reg;
  logic [1:0]       lock_op_reg;
  logic [4:0]       vcnt_reg;
  logic             vok_reg;
  logic [4:0]       lpage_reg;
  logic [31:0]      lock_reg;
  eal_prog_t        prog_reg;
  logic [BUSY_W-1:0] busy_cnt_reg;
  logic [15:0]      pmask_reg;
  logic             sda_oe_reg;
  logic [7:0]       mem [MEM_N];
  logic [7:0]       buf_mem [PAGE_N];
  logic             bit_evt;
  logic             scl_fall;
  logic             start_evt;
  logic             stop_evt;
  logic             bus_evt;
  logic [7:0]       rx_byte;
  logic             rx_done;
  logic             data_go;
  logic             lock_go;
  logic             prog_end;

  // true while the slave is the transmitter
  function automatic logic is_tx(input eal_state_t s);
    is_tx = (s == ST_READ) || (s == ST_LREAD);
  endfunction : is_tx

  // -------------------------------------------------------------------
  // link clock domain
  // -------------------------------------------------------------------
  // sample sda on each rising scl edge and flag it with a toggle
  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      rx_bit_reg <= 1'b0;
      rx_tog_reg <= 1'b0;
    end else begin
      rx_bit_reg <= sda_in;
      rx_tog_reg <= ~rx_tog_reg;
    end
  end

  // -------------------------------------------------------------------
  // crossing into the system clock
  // -------------------------------------------------------------------
  // two-stage synchronisers for toggle and raw pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tog_sync_reg <= 2'h0;
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      tog_last_reg <= 1'b0;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      tog_sync_reg <= {tog_sync_reg[0], rx_tog_reg};
      scl_sync_reg <= {scl_sync_reg[0], scl};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      tog_last_reg <= tog_sync_reg[1];
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end

  // bit value is held stable until the next scl rise, long after the
  // toggle has crossed
  assign bit_evt   = tog_sync_reg[1] ^ tog_last_reg;
  assign scl_fall  = scl_last_reg & ~scl_sync_reg[1];
  assign start_evt = scl_sync_reg[1] & sda_last_reg & ~sda_sync_reg[1];
  assign stop_evt  = scl_sync_reg[1] & ~sda_last_reg & sda_sync_reg[1];
  assign bus_evt   = bit_evt & ~start_evt & ~stop_evt;
  assign rx_byte   = {shift_reg[6:0], rx_bit_reg};
  assign rx_done   = bus_evt && (bitcnt_reg == BIT_LAST);

  // programming launch at stop
  assign data_go = stop_evt && (state_reg == ST_WDATA)
                   && (mask_reg != 16'h0000)
                   && lock_reg[page_reg];                    // RQ4 RQ18
  assign lock_go = stop_evt && (state_reg == ST_VERIFY) && vok_reg
                   && (vcnt_reg == VERIFY_BYTES);            // RQ24

  // -------------------------------------------------------------------
  // protocol engine
  // -------------------------------------------------------------------
  // byte framing, acknowledge decisions and address counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_IDLE;
      bitcnt_reg    <= 4'h0;
      shift_reg     <= 8'h00;
      ack_reg       <= 1'b0;
      addr_reg      <= ADDR_RST;
      page_reg      <= 5'h00;
      cmd_reg       <= 8'h00;
      wcmd_reg      <= 8'h00;
      repeat_ok_reg <= 1'b0;
      mask_reg      <= 16'h0000;
      lock_op_reg   <= 2'h0;
      vcnt_reg      <= 5'h00;
      vok_reg       <= 1'b0;
      lpage_reg     <= 5'h00;
    end else if (start_evt) begin
      // repeated start drops unprogrammed data
      state_reg     <= ST_CMD;
      bitcnt_reg    <= 4'h0;
      ack_reg       <= 1'b0;
      mask_reg      <= 16'h0000;                             // RQ12
      repeat_ok_reg <= (state_reg == ST_WDATA)
                       && (mask_reg == 16'h0000);            // RQ20
    end else if (stop_evt) begin
      state_reg     <= ST_IDLE;
      bitcnt_reg    <= 4'h0;
      ack_reg       <= 1'b0;
      mask_reg      <= 16'h0000;
      repeat_ok_reg <= 1'b0;
      if (lock_go) begin
        addr_reg <= {page_reg, PAGE_TOP};
      end
    end else if (bus_evt && (bitcnt_reg != BIT_ACK)) begin
      bitcnt_reg <= bitcnt_reg + 4'h1;
      // counter steps as the next data byte starts, so a stop leaves
      // it on the last entered address
      if ((state_reg == ST_WDATA) && (bitcnt_reg == 4'h1)
          && (mask_reg != 16'h0000)) begin
        addr_reg[3:0] <= addr_reg[3:0] + 4'h1;               // RQ1 RQ8 RQ11
      end
      if (!is_tx(state_reg)) begin
        shift_reg <= rx_byte;
      end
      if (bitcnt_reg == BIT_LAST) begin
        case (state_reg)
          ST_CMD: begin
            cmd_reg <= rx_byte;
            if ((rx_byte[7:4] == DEV_CODE)
                && (prog_reg == PG_NONE)) begin
              ack_reg <= 1'b1;                               // RQ3
            end else begin
              state_reg <= ST_WAIT;                          // RQ10
            end
          end
          ST_ADDR: begin
            ack_reg  <= 1'b1;
            wcmd_reg <= cmd_reg;
            addr_reg <= {cmd_reg[CMD_A8_BIT], rx_byte};      // RQ3 RQ23
            page_reg <= {cmd_reg[CMD_A8_BIT], rx_byte[7:4]}; // RQ19
          end
          ST_WDATA: begin
            ack_reg <= 1'b1;
            mask_reg[addr_reg[3:0]] <= 1'b1;                 // RQ7 RQ9
          end
          ST_CTL: begin
            ack_reg     <= (rx_byte[1:0] != LOCK_CODE_BAD);
            lock_op_reg <= rx_byte[1:0];                     // RQ21
          end
          ST_VERIFY: begin
            ack_reg <= (vcnt_reg != VERIFY_BYTES) &&
                       (rx_byte == mem[{page_reg, vcnt_reg[3:0]}]); // RQ22
          end
          default: begin
            ack_reg <= 1'b0;
          end
        endcase
      end
    end else if (bus_evt) begin
      // rise of the acknowledge clock
      bitcnt_reg <= 4'h0;
      ack_reg    <= 1'b0;
      case (state_reg)
        ST_CMD: begin
          if (cmd_reg[CMD_RW_BIT]) begin                     // RQ23
            state_reg <= ST_READ;
            shift_reg <= mem[addr_reg];                      // RQ13 RQ14
            addr_reg  <= addr_reg + 9'h001;                  // RQ2 RQ16
          end else if (repeat_ok_reg && (cmd_reg == wcmd_reg)) begin
            state_reg <= ST_CTL;                             // RQ20
          end else begin
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          state_reg <= ST_WDATA;
        end
        ST_WDATA: begin
          state_reg <= ST_WDATA;
        end
        ST_CTL: begin
          if (!ack_reg) begin
            state_reg <= ST_WAIT;
          end else if (lock_op_reg == LOCK_BIT_READ_CODE) begin
            state_reg <= ST_LREAD;
            shift_reg <= {lock_reg[page_reg], 7'h00};        // RQ25
            lpage_reg <= page_reg + 5'h01;
          end else begin
            state_reg <= ST_VERIFY;
            vcnt_reg  <= 5'h00;
            vok_reg   <= 1'b1;
          end
        end
        ST_VERIFY: begin
          if (ack_reg) begin
            vcnt_reg <= vcnt_reg + 5'h01;
          end else begin
            vok_reg <= 1'b0;                                 // RQ22
          end
        end
        ST_READ: begin
          if (!rx_bit_reg) begin
            shift_reg <= mem[addr_reg];                      // RQ15
            addr_reg  <= addr_reg + 9'h001;                  // RQ2 RQ16
          end else begin
            state_reg <= ST_WAIT;                            // RQ15
          end
        end
        ST_LREAD: begin
          if (!rx_bit_reg) begin
            shift_reg <= {lock_reg[lpage_reg], 7'h00};       // RQ25
            lpage_reg <= lpage_reg + 5'h01;
          end else begin
            state_reg <= ST_WAIT;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // page buffer capture, indexed by low address bits
  always_ff @(posedge clk) begin
    if (rx_done && (state_reg == ST_WDATA)) begin
      buf_mem[addr_reg[3:0]] <= rx_byte;                     // RQ7
    end
  end

  // -------------------------------------------------------------------
  // sda driver
  // -------------------------------------------------------------------
  // changes only after a falling scl, released on start and stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_oe_reg <= 1'b0;
    end else if (start_evt || stop_evt) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      if (bitcnt_reg == BIT_ACK) begin
        sda_oe_reg <= ack_reg & ~is_tx(state_reg);           // RQ10
      end else if (is_tx(state_reg)) begin
        sda_oe_reg <= ~shift_reg[~bitcnt_reg[2:0]];          // RQ13
      end else begin
        sda_oe_reg <= 1'b0;
      end
    end
  end

  assign sda_oe  = sda_oe_reg;
  assign sda_out = 1'b0;

  // -------------------------------------------------------------------
  // programming timer and lock bits
  // -------------------------------------------------------------------
  assign prog_end = (prog_reg == PG_DATA)
                    ? (busy_cnt_reg == BUSY_W'(PROG_CYC - 1))
                    : (busy_cnt_reg == BUSY_W'(LOCK_CYC - 1));

  // self-timed cycle; bus stays deaf to commands meanwhile
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_reg     <= PG_NONE;
      busy_cnt_reg <= '0;
      pmask_reg    <= 16'h0000;
      lock_reg     <= LOCK_RST;
    end else begin
      case (prog_reg)
        PG_NONE: begin
          busy_cnt_reg <= '0;
          if (data_go) begin
            prog_reg  <= PG_DATA;                            // RQ4
            pmask_reg <= mask_reg;
          end else if (lock_go) begin
            prog_reg <= PG_LOCK;                             // RQ24
          end
        end
        PG_DATA: begin
          busy_cnt_reg <= busy_cnt_reg + BUSY_W'(1);
          if (prog_end) begin
            prog_reg <= PG_NONE;                             // RQ6 RQ11
          end
        end
        PG_LOCK: begin
          busy_cnt_reg <= busy_cnt_reg + BUSY_W'(1);
          if (prog_end) begin
            prog_reg <= PG_NONE;                             // RQ24
            lock_reg[page_reg] <=
              (lock_op_reg == LOCK_BIT_ERASE_CODE);          // RQ17 RQ21
          end
        end
        default: begin
          prog_reg <= PG_NONE;
        end
      endcase
    end
  end

  // erase selected bytes first, write buffer at the end
  always_ff @(posedge clk) begin
    for (int i = 0; i < PAGE_N; i++) begin
      if ((prog_reg == PG_DATA) && pmask_reg[i]) begin
        if (busy_cnt_reg == '0) begin
          mem[{page_reg, OFS_W'(i)}] <= ERASED_BYTE;         // RQ5
        end else if (prog_end) begin
          mem[{page_reg, OFS_W'(i)}] <= buf_mem[i];          // RQ5 RQ9
        end
      end
    end
  end

  assign busy = (prog_reg != PG_NONE);
endmodule : eal_eeprom_slave
`default_nettype wire

// >>> logic/eal_pkg.sv
/*
  Shared constants and types of the serial eeprom access block with
  page lock bits. Assumes a 100 MHz system clock and a bus master
  that drives the serial clock.
*/
`default_nettype none
package eal_pkg;
  // -------------------------------------------------------------------
  // memory geometry
  // -------------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int PAGE_W = 5;
  localparam int OFS_W  = 4;
  localparam int PAGE_N = 16;
  localparam int MEM_N  = 512;
  localparam int LOCK_N = 32;

  // -------------------------------------------------------------------
  // command and control byte fields
  // -------------------------------------------------------------------
  localparam logic [3:0] DEV_CODE       = 4'hA;
  localparam int         CMD_RW_BIT     = 0;
  localparam int         CMD_A8_BIT     = 1;
  localparam logic [1:0] LOCK_BIT_READ_CODE  = 2'h0;
  localparam logic [1:0] LOCK_BIT_WRITE_CODE = 2'h1;
  localparam logic [1:0] LOCK_BIT_ERASE_CODE = 2'h3;
  localparam logic [1:0] LOCK_CODE_BAD  = 2'h2;
  localparam logic [3:0] BIT_LAST       = 4'h7;
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam logic [4:0] VERIFY_BYTES   = 5'h10;
  localparam logic [3:0] PAGE_TOP       = 4'hF;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [31:0] LOCK_RST    = 32'hFFFF_FFFF;
  localparam logic [8:0]  ADDR_RST    = 9'h000;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int PROG_TIME_MS = 8;
  localparam int LOCK_TIME_MS = 4;
  localparam int PROG_CYC_DEF = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int LOCK_CYC_DEF = LOCK_TIME_MS * (CLK_HZ / 1000);
  localparam int BUSY_W       = 20;

  // -------------------------------------------------------------------
  // states
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_CMD    = 4'h1,
    ST_ADDR   = 4'h2,
    ST_WDATA  = 4'h3,
    ST_CTL    = 4'h4,
    ST_VERIFY = 4'h5,
    ST_READ   = 4'h6,
    ST_LREAD  = 4'h7,
    ST_WAIT   = 4'h8
  } eal_state_t;

  typedef enum logic [1:0] {
    PG_NONE = 2'h0,
    PG_DATA = 2'h1,
    PG_LOCK = 2'h2
  } eal_prog_t;
endpackage : eal_pkg
`default_nettype wire

// >>> test/eal_bus_master.sv
/*
  Bus master model: moves scl and pulls sda on link clock ticks.
  Assumes sda is the resolved wire with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none
module eal_bus_master (
  // timebase and pace
  input  wire logic       lclk,
  input  wire logic       slow,
  // bus
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_pull,
  // results seen
  output logic [7:0]      obs_val,
  output logic            obs_tgl
);
  // idle bus: clock stands high, data released
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    obs_val  = 8'h00;
    obs_tgl  = 1'b0;
  end
  // wait ticks, one more per phase when slow
  task automatic tk(input int n);
    repeat (n + int'(slow)) @(posedge lclk);
  endtask : tk
  // one clock: send b, sample line mid high
  task automatic bit_x(input logic b, output logic r);
    tk(1);
    sda_pull = !b;
    tk(1);
    scl = 1'b1;
    tk(1);
    r = sda;
    tk(1);
    scl = 1'b0;
  endtask : bit_x
  // start or repeated start
  task automatic start();
    tk(1);
    sda_pull = 1'b0;
    tk(1);
    scl = 1'b1;
    tk(2);
    sda_pull = 1'b1;
    tk(2);
    scl = 1'b0;
  endtask : start
  // stop, clock then stands high
  task automatic stop();
    tk(1);
    sda_pull = 1'b1;
    tk(1);
    scl = 1'b1;
    tk(2);
    sda_pull = 1'b0;
    tk(2);
  endtask : stop
  // byte out, ninth clock read as ack
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    obs_val = {7'h00, r};
    obs_tgl = !obs_tgl;
  endtask : wbyte
  // byte in, then ack or release
  task automatic rbyte(input logic ack);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(!ack, r);
    obs_val = v;
    obs_tgl = !obs_tgl;
  endtask : rbyte
endmodule : eal_bus_master
`default_nettype wire

// >>> test/eal_checker.sv
/*
  Checker of busy timing and sda drive of the eeprom slave.
  Assumes binding to eal_eeprom_slave with its parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module eal_checker #(
  parameter int PROG_CYC = 2000,
  parameter int LOCK_CYC = 1000
) (
  // system
  input wire logic clk,
  input wire logic nrst,
  // link and status
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic busy
);
  logic [1:0]  scl_s;
  logic [1:0]  sda_s;
  logic [7:0]  stop_age;
  logic [7:0]  low_age;
  logic [19:0] bcnt;

  // synced lines, stop age, scl low age, busy length
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s    <= 2'h3;
      sda_s    <= 2'h3;
      stop_age <= 8'hFF;
      low_age  <= 8'h00;
      bcnt     <= 20'h00000;
    end else begin
      scl_s    <= {scl_s[0], scl};
      sda_s    <= {sda_s[0], sda_in};
      if (scl_s[1] && sda_s == 2'h1)
        stop_age <= 8'h00;
      else if (stop_age != 8'hFF)
        stop_age <= stop_age + 8'h01;
      low_age  <= scl ? 8'h00 : low_age + {7'h00, low_age != 8'hFF};
      bcnt     <= busy ? bcnt + 20'h00001 : 20'h00000;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_run8;
    busy [*8];
  endsequence
  sequence s_stop_seen;
    stop_age < 8'h0C;
  endsequence

  property p_low_only; sda_oe |-> !sda_out; endproperty
  a_low_only: assert property (p_low_only)
    else $error("sda driven high");
  property p_busy_len;
    $fell(busy) |-> (bcnt == 20'(PROG_CYC)) || (bcnt == 20'(LOCK_CYC));
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_busy_cap; busy |-> bcnt < 20'(PROG_CYC); endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("busy too long");
  property p_busy_start; $rose(busy) |-> s_stop_seen; endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy without stop");
  property p_busy_min; $rose(busy) |-> s_run8; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  property p_poll_quiet; busy |-> !sda_oe; endproperty
  a_poll_quiet: assert property (p_poll_quiet)
    else $error("sda driven while busy");
  property p_drive_low; $rose(sda_oe) |-> !scl; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("sda taken while scl high");
  property p_drive_delay;
    $rose(sda_oe) |-> low_age inside {[8'h01:8'h08]};
  endproperty
  a_drive_delay: assert property (p_drive_delay)
    else $error("sda drive late");
endmodule : eal_checker

bind eal_eeprom_slave eal_checker #(
  .PROG_CYC(PROG_CYC),
  .LOCK_CYC(LOCK_CYC)
) chk_u (
  .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy)
);
`default_nettype wire

// >>> test/eal_eeprom_slave_test.sv
/*
  Self-checking bench of the eeprom slave and a bus master model.
  Assumes eal_pkg, the slave, the master model and the checker.
*/
`timescale 1ns/1ns
`default_nettype none
module eal_eeprom_slave_test;
  import eal_pkg::*;
  localparam int         PROG   = 2000;
  localparam int         LOCKC  = 1000;
  localparam logic [7:0] ACK    = 8'h00;
  localparam logic [7:0] NAK    = 8'h01;
  localparam logic [7:0] CMD_RD = {DEV_CODE, 4'h1};
  logic       clk, nrst, lclk, slow, scl, pull;
  logic       sda_out, sda_oe, busy, tgl;
  logic [7:0] obs, e;
  logic [7:0] mem [MEM_N];
  logic [7:0] exp_q [$];
  int         mismatches, tests_run, cyc;
  wire logic  sda;

  // wired-and data line with pull-up, clocks
  assign sda = !((sda_oe && !sda_out) || pull);
  always #5 clk = !clk;
  always #32 lclk = !lclk;

  eal_eeprom_slave #(.PROG_CYC(PROG), .LOCK_CYC(LOCKC)) dut_u (
    .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy)
  );
  eal_bus_master m_u (
    .lclk(lclk), .slow(slow), .sda(sda), .scl(scl),
    .sda_pull(pull), .obs_val(obs), .obs_tgl(tgl)
  );

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  function automatic logic [7:0] cw(input logic a8);
    return {DEV_CODE, 2'b00, a8, 1'b0};
  endfunction : cw
  // note the expected result, then run the byte
  task automatic wr(input logic [7:0] b, input logic [7:0] x);
    exp_q.push_back(x);
    m_u.wbyte(b);
  endtask : wr
  task automatic cmd(input logic [7:0] b, input logic [7:0] x);
    m_u.start();
    wr(b, x);
  endtask : cmd
  task automatic rd(input logic [7:0] x, input logic ack);
    exp_q.push_back(x);
    m_u.rbyte(ack);
  endtask : rd
  task automatic at(input logic [8:0] a);
    cmd(cw(a[8]), ACK);
    wr(a[7:0], ACK);
  endtask : at
  task automatic lk(input logic [8:0] a, input logic [7:0] c,
                    input logic [7:0] x);
    at(a);
    cmd(cw(a[8]), ACK);
    wr(c, x);
  endtask : lk
  task automatic pw(input logic [8:0] a, input int n, input logic upd);
    logic [7:0] d;
    at(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wr(d, ACK);
      if (upd) mem[{a[8:4], 4'(a[3:0] + i)}] = d;
    end
    m_u.stop();
  endtask : pw
  task automatic idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
  endtask : idle

  // compare each result with the oldest note
  initial begin
    wait (nrst === 1'b1);
    forever begin
      @(tgl);
      e = exp_q.pop_front();
      tests_run++;
      if (obs !== e) begin
        mismatches++;
        $display("BAD bus byte expected %h seen %h", e, obs);
      end
    end
  end
  // cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      final_report();
    end
  end

  // main sequence
  initial begin
    clk = 1'b0;
    lclk = 1'b0;
    nrst = 1'b0;
    slow = 1'b0;
    mismatches = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(30259));
    repeat (16) @(posedge clk);
    #2 nrst = 1'b1;
    slow = 1'($urandom);
    pw(9'h1F5, 16, 1'b1);
    cmd(cw(1'b0), NAK);
    m_u.stop();
    idle();
    pw(9'h005, 16, 1'b1);
    idle();
    $display("test fill done");
    at(9'h1FE);
    cmd(CMD_RD, ACK);
    for (int i = 0; i < 4; i++) rd(mem[9'(510 + i)], i < 3);
    m_u.stop();
    cmd(CMD_RD, ACK);
    rd(mem[2], 1'b0);
    m_u.stop();
    pw(9'h00E, 2, 1'b1);
    idle();
    cmd(CMD_RD, ACK);
    rd(mem[15], 1'b0);
    m_u.stop();
    at(9'h000);
    cmd(CMD_RD, ACK);
    for (int i = 0; i < 16; i++) rd(mem[i], i < 15);
    m_u.stop();
    $display("test read done");
    slow = 1'($urandom);
    lk(9'h003, 8'h01, ACK);
    for (int i = 0; i < 16; i++) wr(mem[i], ACK);
    m_u.stop();
    idle();
    lk(9'h1F0, 8'hFC, ACK);
    rd(8'h80, 1'b1);
    rd(8'h00, 1'b1);
    rd(8'h80, 1'b0);
    m_u.stop();
    pw(9'h005, 1, 1'b0);
    at(9'h005);
    cmd(CMD_RD, ACK);
    rd(mem[5], 1'b0);
    m_u.stop();
    $display("test lock done");
    lk(9'h000, 8'h02, NAK);
    m_u.stop();
    lk(9'h000, 8'h03, ACK);
    wr(~mem[0], NAK);
    m_u.stop();
    lk(9'h000, 8'h00, ACK);
    rd(8'h00, 1'b0);
    m_u.stop();
    lk(9'h000, 8'h03, ACK);
    for (int i = 0; i < 16; i++) wr(mem[i], ACK);
    m_u.stop();
    idle();
    pw(9'h005, 1, 1'b1);
    idle();
    at(9'h005);
    cmd(CMD_RD, ACK);
    rd(mem[5], 1'b0);
    m_u.stop();
    $display("test erase done");
    final_report();
  end
endmodule : eal_eeprom_slave_test
`default_nettype wire
